// ==== efcb_pkg.sv ====
/*
 egress/ingress flow control buffer: shared constants, field positions, event indexes, state types.
 assumes a single 100 MHz clock and a word-wide packet stream with last/special flags.
*/
`default_nettype none
package efcb_pkg;
	localparam int EFCB_DATA_W = 64;
	localparam int EFCB_MTU_BYTES = 10240;
	localparam int EFCB_MTU_MULT = 4;
	localparam int EFCB_CTRL_MAX_BYTES = 64;
	localparam int EFCB_PAUSE_QUANTUM_BITS = 512;
	localparam int EFCB_CLK_PERIOD_PS = 10000;
	localparam int EFCB_BIT_TIME_PS = 1000;
	// least time: rounded up to whole cycles
	localparam int EFCB_QUANTUM_CYCLES = (EFCB_PAUSE_QUANTUM_BITS * EFCB_BIT_TIME_PS
		+ EFCB_CLK_PERIOD_PS - 1) / EFCB_CLK_PERIOD_PS;
	localparam int EFCB_QUANTA_W = 16;
	localparam int EFCB_CNT_W = 32;
	localparam int EFCB_Q_CTRL = 0;
	localparam int EFCB_Q_DATA = 1;
	// flag positions above the data bits of a stored word
	localparam int EFCB_FLAG_LAST = 0;
	localparam int EFCB_FLAG_SPECIAL = 1;
	localparam int EFCB_FLAG_ABORT = 2;
	localparam int EFCB_EV_CTRL_OVF = 0;
	localparam int EFCB_EV_CTRL_ECC = 1;
	localparam int EFCB_EV_DATA_ECC = 2;
	localparam int EFCB_EV_RX_OVF = 3;
	localparam int EFCB_EV_PAUSE_RCVD = 4;
	localparam int EFCB_NUM_CNT = 4;
	localparam int EFCB_NUM_STICKY = 5;
	localparam logic [EFCB_CNT_W-1:0] EFCB_CNT_RESET = 32'h0000_0000;
	typedef enum logic [1:0] {EFCB_RS_IDLE, EFCB_RS_CTRL, EFCB_RS_DATA} efcb_rd_state_e;
	typedef enum logic {EFCB_RUN, EFCB_PAUSED} efcb_pause_state_e;
endpackage
`default_nettype wire

// ==== efcb_mem.sv ====
/*
 simple dual-port buffer ram, one write and one registered read per cycle.
 assumes the caller keeps addresses below DEPTH; contents are not reset.
*/
`default_nettype none
module efcb_mem
	import efcb_pkg::*;
#(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16,
	localparam int AW = $clog2(DEPTH)
)(
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic wr_en_in,
	input wire logic [AW-1:0] wr_addr_in,
	input wire logic [WIDTH-1:0] wr_data_in,
	input wire logic rd_en_in,
	input wire logic [AW-1:0] rd_addr_in,
	output logic [WIDTH-1:0] rd_data_out
);
	logic [WIDTH-1:0] ram [DEPTH];
	logic [WIDTH-1:0] next_rd_data;

	always_comb
	begin
		next_rd_data = rd_en_in ? ram[rd_addr_in] : rd_data_out;
	end

	always_ff @(posedge clk_in)
	begin
		if (wr_en_in)
		begin
			ram[wr_addr_in] <= wr_data_in;
		end
		if (!rstn_in)
		begin
			rd_data_out <= '0;
		end
		else
		begin
			rd_data_out <= next_rd_data;
		end
	end
endmodule
`default_nettype wire

// ==== efcb_buffer.sv ====
/*
 flow control buffer: egress control/data queues in one ecc ram, pause reaction, xoff/xon
 requests to the host mac, ingress two-entry buffer and drop statistics.
 assumes all inputs come from logic on clk_in; line mac pulses pause indications.
*/
// Behaviour
// - egress frames are buffered; full queue pulls ready low toward the host
// - ingress words pass a buffer so the host mac may stall to insert pauses
// - egress control queue is always served before the data queue
// - control frames still leave toward the line while paused
// - valid/ready buffers absorb rate differences between line and host sides
// - link fault, lpi and idle control words travel in-band both ways
// - egress storage equals four maximum transmission units
// - buffer ram is ecc protected; uncorrectable read-back aborts the frame
// - every dropped frame is counted; events set sticky status bits
// - line mac pause indication with quanta reaches the egress buffer
// - pause state entered at next frame boundary; timer starts only then
// - paused: no data frames drained, filling continues at full speed
// - merge on and paused by the line raises xoff toward host mac
// - xoff raised at xoff threshold, xon given at xon threshold
// - xoff leaves room for one more jumbo frame
// - pause reaction enable switches pause reaction and timer on
// - pause signal enable switches threshold xoff/xon requests on
// - merge clear: thresholds only; set: line pause also merged in
// - queued control frames go at the next boundary ahead of waiting data
// - control queue enable decides whether the control queue is used
// - ram split between queues by start and end boundaries per queue
// - one pause quantum is 512 bit times; timer counts quanta
// - drop counters are 32 bits and wrap to zero
`default_nettype none
module efcb_buffer
	import efcb_pkg::*;
#(
	parameter int DATA_W = EFCB_DATA_W,
	parameter int MTU_BYTES = EFCB_MTU_BYTES,
	parameter int QUANTUM_CYCLES = EFCB_QUANTUM_CYCLES,
	localparam int MTU_WORDS = MTU_BYTES / (DATA_W / 8),
	localparam int DEPTH = EFCB_MTU_MULT * MTU_WORDS,
	localparam int ADDR_W = $clog2(DEPTH)
)(
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic pause_reaction_enable_in,
	input wire logic host_pause_signal_enable_in,
	input wire logic merge_line_pause_into_request_in,
	input wire logic egress_control_queue_enable_in,
	input wire logic [ADDR_W:0] xoff_threshold_in,
	input wire logic [ADDR_W:0] xon_threshold_in,
	input wire logic [ADDR_W-1:0] ctrl_queue_start_in,
	input wire logic [ADDR_W-1:0] ctrl_queue_end_in,
	input wire logic [ADDR_W-1:0] data_queue_start_in,
	input wire logic [ADDR_W-1:0] data_queue_end_in,
	input wire logic ecc_inject_single_in,
	input wire logic ecc_inject_double_in,
	input wire logic line_pause_valid_in,
	input wire logic [EFCB_QUANTA_W-1:0] line_pause_quanta_in,
	input wire logic eg_valid_in,
	output logic eg_ready_out,
	input wire logic [DATA_W-1:0] eg_data_in,
	input wire logic eg_last_in,
	input wire logic eg_special_in,
	input wire logic eg_mac_ctrl_in,
	output logic eg_out_valid_out,
	input wire logic eg_out_ready_in,
	output logic [DATA_W-1:0] eg_out_data_out,
	output logic eg_out_last_out,
	output logic eg_out_special_out,
	output logic eg_out_abort_out,
	input wire logic ig_valid_in,
	input wire logic [DATA_W-1:0] ig_data_in,
	input wire logic ig_last_in,
	input wire logic ig_special_in,
	output logic ig_out_valid_out,
	input wire logic ig_out_ready_in,
	output logic [DATA_W-1:0] ig_out_data_out,
	output logic ig_out_last_out,
	output logic ig_out_special_out,
	output logic ig_out_abort_out,
	output logic host_pause_request_out,
	output logic egress_paused_out,
	output logic [ADDR_W:0] data_fill_out,
	output logic [EFCB_CNT_W-1:0] ctrl_overflow_drops_out,
	output logic [EFCB_CNT_W-1:0] ctrl_ecc_drops_out,
	output logic [EFCB_CNT_W-1:0] data_ecc_drops_out,
	output logic [EFCB_CNT_W-1:0] ingress_overflow_drops_out,
	output logic [EFCB_NUM_STICKY-1:0] sticky_out,
	input wire logic [EFCB_NUM_STICKY-1:0] sticky_clear_in
);
	localparam int DW = DATA_W + 2;
	localparam int MW = 2 * (DW + 1);
	localparam int FW = DATA_W + 3;
	localparam logic [ADDR_W:0] ONE = (ADDR_W + 1)'(1);
	localparam logic [ADDR_W:0] JUMBO_WORDS = (ADDR_W + 1)'(MTU_WORDS);
	localparam logic [ADDR_W:0] CTRL_MAX_WORDS = (ADDR_W + 1)'(EFCB_CTRL_MAX_BYTES / (DATA_W / 8));
	localparam logic [EFCB_QUANTA_W-1:0] Q_LAST = EFCB_QUANTA_W'(QUANTUM_CYCLES - 1);
	localparam logic [MW-1:0] INJ_ONE = MW'(1);
	localparam logic [MW-1:0] INJ_TWO = MW'(1) | (MW'(1) << (DW + 2));

	////////////////////////////////////////////////////////////////////////////////
	// two copies plus parity each: one flip is corrected, differing bad copies are not
	function automatic logic [MW-1:0] ecc_enc(input logic [DW-1:0] d);
		ecc_enc = {^d, d, ^d, d};
	endfunction

	function automatic logic [DW:0] ecc_dec(input logic [MW-1:0] w);
		logic [DW-1:0] c0;
		logic [DW-1:0] c1;
		c0 = w[DW-1:0];
		c1 = w[2*DW:DW+1];
		if (c0 == c1)
			ecc_dec = {1'b0, c0};
		else if ((^c0 == w[DW]) && (^c1 != w[MW-1]))
			ecc_dec = {1'b0, c0};
		else if ((^c1 == w[MW-1]) && (^c0 != w[DW]))
			ecc_dec = {1'b0, c1};
		else
			ecc_dec = {1'b1, c0};
	endfunction

	function automatic logic [ADDR_W-1:0] next_ptr(input logic [ADDR_W-1:0] p,
		input logic [ADDR_W-1:0] s, input logic [ADDR_W-1:0] e);
		next_ptr = (p == e) ? s : ADDR_W'(p + 1'b1);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	logic [ADDR_W-1:0] qstart [2];
	logic [ADDR_W-1:0] qend [2];
	logic [ADDR_W:0] cap [2];
	logic [ADDR_W-1:0] wr_ptr [2];
	logic [ADDR_W-1:0] rd_ptr [2];
	logic [ADDR_W:0] fill [2];
	logic [ADDR_W:0] frames [2];
	logic [ADDR_W-1:0] next_wr_ptr [2];
	logic [ADDR_W-1:0] next_rd_ptr [2];
	logic [ADDR_W:0] next_fill [2];
	logic [ADDR_W:0] next_frames [2];
	logic wr_in_frame, wr_ctrl, wr_drop, next_wr_in_frame, next_wr_ctrl, next_wr_drop;
	logic start_ctrl, start_drop, cur_ctrl, drop_cur, wq, wr_en, wr_last;
	logic [MW-1:0] wr_word, mem_rd;
	efcb_rd_state_e rs, next_rs;
	logic inflight, inflight_q, frame_abort, next_frame_abort, rd_q, rd_issue;
	logic [DW:0] dec;
	logic ret_last, ret_unc;
	efcb_pause_state_e pstate, next_pstate;
	logic pend, next_pend, pause_hold;
	logic [EFCB_QUANTA_W-1:0] pend_q, next_pend_q, left, next_left, sub, next_sub;
	logic xoff_state, next_xoff_state, next_host_req;
	logic [ADDR_W:0] room_lim, eff_xoff;
	logic ig_in_frame, ig_drop, next_ig_in_frame, next_ig_drop;
	logic [FW-1:0] slot [2][2];
	logic [1:0] cnt [2];
	logic push [2];
	logic pop [2];
	logic mark [2];
	logic [FW-1:0] push_word [2];
	logic [EFCB_NUM_STICKY-1:0] ev;
	logic [EFCB_CNT_W-1:0] drops [EFCB_NUM_CNT];

	// per-queue regions of the shared ram
	assign qstart[EFCB_Q_CTRL] = ctrl_queue_start_in;
	assign qend[EFCB_Q_CTRL] = ctrl_queue_end_in;
	assign qstart[EFCB_Q_DATA] = data_queue_start_in;
	assign qend[EFCB_Q_DATA] = data_queue_end_in;
	assign cap[0] = {1'b0, qend[0]} - {1'b0, qstart[0]} + ONE;
	assign cap[1] = {1'b0, qend[1]} - {1'b0, qstart[1]} + ONE;

	////////////////////////////////////////////////////////////////////////////////
	// egress write side
	// control queue used only when enabled
	assign start_ctrl = eg_mac_ctrl_in & egress_control_queue_enable_in & ~eg_special_in;
	// control frames are dropped rather than stalling the data behind them
	assign start_drop = start_ctrl & ((cap[0] - fill[0]) < CTRL_MAX_WORDS);
	assign cur_ctrl = wr_in_frame ? wr_ctrl : start_ctrl;
	assign drop_cur = wr_in_frame ? wr_drop : start_drop;
	assign wq = ~cur_ctrl;
	// back-pressure toward the host; not gated by the pause state
	assign eg_ready_out = drop_cur | (fill[wq] != cap[wq]);
	assign wr_en = eg_valid_in & eg_ready_out & ~drop_cur;
	// an in-band control word is stored as a one-word frame
	assign wr_last = eg_last_in | eg_special_in;
	assign wr_word = ecc_enc({eg_special_in, wr_last, eg_data_in})
		^ (ecc_inject_double_in ? INJ_TWO : (ecc_inject_single_in ? INJ_ONE : '0));

	always_comb
	begin
		next_wr_in_frame = wr_in_frame;
		next_wr_ctrl = wr_ctrl;
		next_wr_drop = wr_drop;
		if (eg_valid_in && eg_ready_out)
		begin
			if (!wr_in_frame)
			begin
				next_wr_ctrl = start_ctrl;
				next_wr_drop = start_drop;
			end
			next_wr_in_frame = ~wr_last;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// egress read side: one read in flight, a word returns the cycle after issue
	assign rd_q = (rs == EFCB_RS_CTRL) ? 1'b0 : 1'b1;
	assign rd_issue = (rs != EFCB_RS_IDLE) & ~inflight & (cnt[0] != 2'd2) & (fill[rd_q] != '0);
	assign dec = ecc_dec(mem_rd);
	assign ret_last = dec[DATA_W + EFCB_FLAG_LAST];
	assign ret_unc = dec[DW];
	assign pause_hold = (pstate == EFCB_PAUSED) | pend;

	always_comb
	begin
		next_rs = rs;
		case (rs)
			EFCB_RS_IDLE:
			begin
				// control first at every boundary; pause ignored here
				if ((frames[0] != '0) && egress_control_queue_enable_in)
					next_rs = EFCB_RS_CTRL;
				// no data frame starts while paused or pause pending
				else if ((frames[1] != '0) && !pause_hold)
					next_rs = EFCB_RS_DATA;
			end
			EFCB_RS_CTRL, EFCB_RS_DATA:
			begin
				if (inflight && ret_last)
					next_rs = EFCB_RS_IDLE;
			end
			default: next_rs = EFCB_RS_IDLE;
		endcase
		// abort the rest of a frame after an uncorrectable word
		next_frame_abort = frame_abort;
		if (inflight)
			next_frame_abort = ret_last ? 1'b0 : (frame_abort | ret_unc);
	end

	always_comb
	begin
		for (int q = 0; q < 2; q++)
		begin
			next_wr_ptr[q] = wr_ptr[q];
			next_rd_ptr[q] = rd_ptr[q];
			next_fill[q] = fill[q];
			next_frames[q] = frames[q];
			if (wr_en && (int'(wq) == q))
			begin
				next_wr_ptr[q] = next_ptr(wr_ptr[q], qstart[q], qend[q]);
				next_fill[q] = next_fill[q] + ONE;
				if (wr_last)
					next_frames[q] = next_frames[q] + ONE;
			end
			if (rd_issue && (int'(rd_q) == q))
			begin
				next_rd_ptr[q] = next_ptr(rd_ptr[q], qstart[q], qend[q]);
				next_fill[q] = next_fill[q] - ONE;
			end
			if (inflight && ret_last && (int'(inflight_q) == q))
				next_frames[q] = next_frames[q] - ONE;
		end
	end

	efcb_mem #(
		.WIDTH(MW),
		.DEPTH(DEPTH)
	) u_mem (
		.clk_in(clk_in),
		.rstn_in(rstn_in),
		.wr_en_in(wr_en),
		.wr_addr_in(wr_ptr[wq]),
		.wr_data_in(wr_word),
		.rd_en_in(rd_issue),
		.rd_addr_in(rd_ptr[rd_q]),
		.rd_data_out(mem_rd)
	);

	////////////////////////////////////////////////////////////////////////////////
	// pause reaction
	always_comb
	begin
		next_pstate = pstate;
		next_pend = pend;
		next_pend_q = pend_q;
		next_left = left;
		next_sub = sub;
		// reaction and timer only when enabled
		if (!pause_reaction_enable_in)
		begin
			next_pstate = EFCB_RUN;
			next_pend = 1'b0;
		end
		// pause indication with quanta from the line mac
		else if (line_pause_valid_in)
		begin
			if (line_pause_quanta_in == '0)
			begin
				next_pend = 1'b0;
				next_pstate = EFCB_RUN;
			end
			else if (pstate == EFCB_PAUSED)
			begin
				next_left = line_pause_quanta_in;
				next_sub = '0;
			end
			else
			begin
				next_pend = 1'b1;
				next_pend_q = line_pause_quanta_in;
			end
		end
		// enter at a frame boundary, timer loaded on entry; a new nonzero pause while paused reloads it
		else if (pstate == EFCB_RUN)
		begin
			if (pend && (rs == EFCB_RS_IDLE))
			begin
				next_pstate = EFCB_PAUSED;
				next_left = pend_q;
				next_sub = '0;
				next_pend = 1'b0;
			end
		end
		// each quantum is 512 bit times of clock cycles
		else if (sub == Q_LAST)
		begin
			next_sub = '0;
			if (left <= 16'h0001)
				next_pstate = EFCB_RUN;
			else
				next_left = left - 16'h0001;
		end
		else
			next_sub = sub + 16'h0001;
	end

	////////////////////////////////////////////////////////////////////////////////
	// host pause request
	// cap the xoff level so a jumbo frame still fits above it
	assign room_lim = (cap[1] > JUMBO_WORDS) ? (cap[1] - JUMBO_WORDS) : '0;
	assign eff_xoff = (xoff_threshold_in < room_lim) ? xoff_threshold_in : room_lim;

	always_comb
	begin
		next_xoff_state = xoff_state;
		if (!host_pause_signal_enable_in)
			next_xoff_state = 1'b0;
		else if (fill[1] >= eff_xoff)
			next_xoff_state = 1'b1;
		else if (fill[1] <= xon_threshold_in)
			next_xoff_state = 1'b0;
		// line pause merged only when the merge setting is on
		next_host_req = (host_pause_signal_enable_in & xoff_state)
			| (merge_line_pause_into_request_in & (pstate == EFCB_PAUSED));
	end

	////////////////////////////////////////////////////////////////////////////////
	// output buffers: 0 egress toward the line, 1 ingress toward the host
	assign push[0] = inflight;
	assign push_word[0] = {ret_unc | frame_abort, dec[DW-1:0]};
	assign mark[0] = 1'b0;
	// line side cannot stall: buffer the host mac's stalls, drop on overflow
	assign push[1] = ig_valid_in & ~ig_drop & ((cnt[1] != 2'd2) | pop[1]);
	assign push_word[1] = {1'b0, ig_special_in, ig_last_in, ig_data_in};
	assign mark[1] = ig_valid_in & ~ig_drop & ~push[1] & ig_in_frame;
	assign pop[0] = (cnt[0] != 2'd0) & eg_out_ready_in;
	assign pop[1] = (cnt[1] != 2'd0) & ig_out_ready_in;

	always_comb
	begin
		next_ig_in_frame = ig_valid_in ? ~ig_last_in : ig_in_frame;
		next_ig_drop = ig_drop;
		if (ig_valid_in && !push[1])
			next_ig_drop = ~ig_last_in;
	end

	generate
		for (genvar gi = 0; gi < 2; gi++)
		begin : g_buf
			logic [FW-1:0] next_s0, next_s1;
			logic [1:0] next_cnt;
			always_comb
			begin
				next_s0 = slot[gi][0];
				next_s1 = slot[gi][1];
				next_cnt = cnt[gi];
				case ({push[gi], pop[gi]})
					2'b10:
					begin
						if (cnt[gi] == 2'd0)
							next_s0 = push_word[gi];
						else
							next_s1 = push_word[gi];
						next_cnt = cnt[gi] + 2'd1;
					end
					2'b01:
					begin
						next_s0 = slot[gi][1];
						next_cnt = cnt[gi] - 2'd1;
					end
					2'b11:
					begin
						next_s0 = (cnt[gi] == 2'd1) ? push_word[gi] : slot[gi][1];
						next_s1 = push_word[gi];
					end
					default: next_cnt = cnt[gi];
				endcase
				// truncated frame: newest word closes it as aborted
				if (mark[gi])
				begin
					next_s1[DATA_W + EFCB_FLAG_LAST] = 1'b1;
					next_s1[DATA_W + EFCB_FLAG_ABORT] = 1'b1;
				end
			end
			always_ff @(posedge clk_in)
			begin
				if (!rstn_in)
				begin
					slot[gi][0] <= '0;
					slot[gi][1] <= '0;
					cnt[gi] <= 2'd0;
				end
				else
				begin
					slot[gi][0] <= next_s0;
					slot[gi][1] <= next_s1;
					cnt[gi] <= next_cnt;
				end
			end
		end
	endgenerate

	assign eg_out_valid_out = cnt[0] != 2'd0;
	assign eg_out_data_out = slot[0][0][DATA_W-1:0];
	assign eg_out_last_out = slot[0][0][DATA_W + EFCB_FLAG_LAST];
	assign eg_out_special_out = slot[0][0][DATA_W + EFCB_FLAG_SPECIAL];
	assign eg_out_abort_out = slot[0][0][DATA_W + EFCB_FLAG_ABORT];
	assign ig_out_valid_out = cnt[1] != 2'd0;
	assign ig_out_data_out = slot[1][0][DATA_W-1:0];
	assign ig_out_last_out = slot[1][0][DATA_W + EFCB_FLAG_LAST];
	assign ig_out_special_out = slot[1][0][DATA_W + EFCB_FLAG_SPECIAL];
	assign ig_out_abort_out = slot[1][0][DATA_W + EFCB_FLAG_ABORT];
	assign egress_paused_out = pstate == EFCB_PAUSED;
	assign data_fill_out = fill[1];

	////////////////////////////////////////////////////////////////////////////////
	// statistics and sticky events
	// one event per dropped or aborted frame, and one per pause indication received while pause reaction is enabled
	assign ev[EFCB_EV_CTRL_OVF] = eg_valid_in & ~wr_in_frame & start_drop;
	assign ev[EFCB_EV_CTRL_ECC] = inflight & ret_unc & ~frame_abort & ~inflight_q;
	assign ev[EFCB_EV_DATA_ECC] = inflight & ret_unc & ~frame_abort & inflight_q;
	assign ev[EFCB_EV_RX_OVF] = ig_valid_in & ~ig_drop & ~push[1];
	assign ev[EFCB_EV_PAUSE_RCVD] = line_pause_valid_in & pause_reaction_enable_in;
	assign ctrl_overflow_drops_out = drops[EFCB_EV_CTRL_OVF];
	assign ctrl_ecc_drops_out = drops[EFCB_EV_CTRL_ECC];
	assign data_ecc_drops_out = drops[EFCB_EV_DATA_ECC];
	assign ingress_overflow_drops_out = drops[EFCB_EV_RX_OVF];

	generate
		for (genvar ci = 0; ci < EFCB_NUM_CNT; ci++)
		begin : g_cnt
			always_ff @(posedge clk_in)
			begin
				if (!rstn_in)
					drops[ci] <= EFCB_CNT_RESET;
				else
					drops[ci] <= drops[ci] + EFCB_CNT_W'(ev[ci]);
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk_in)
	begin
		if (!rstn_in)
		begin
			for (int q = 0; q < 2; q++)
			begin
				wr_ptr[q] <= '0;
				rd_ptr[q] <= '0;
				fill[q] <= '0;
				frames[q] <= '0;
			end
			wr_in_frame <= 1'b0;
			wr_ctrl <= 1'b0;
			wr_drop <= 1'b0;
			rs <= EFCB_RS_IDLE;
			inflight <= 1'b0;
			inflight_q <= 1'b0;
			frame_abort <= 1'b0;
			pstate <= EFCB_RUN;
			pend <= 1'b0;
			pend_q <= '0;
			left <= '0;
			sub <= '0;
			xoff_state <= 1'b0;
			host_pause_request_out <= 1'b0;
			ig_in_frame <= 1'b0;
			ig_drop <= 1'b0;
			sticky_out <= '0;
		end
		else
		begin
			// a queue region must be reprogrammed only while empty; pointers reset to zero, not to the region start
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			fill <= next_fill;
			frames <= next_frames;
			wr_in_frame <= next_wr_in_frame;
			wr_ctrl <= next_wr_ctrl;
			wr_drop <= next_wr_drop;
			rs <= next_rs;
			inflight <= rd_issue;
			inflight_q <= rd_issue ? rd_q : inflight_q;
			frame_abort <= next_frame_abort;
			pstate <= next_pstate;
			pend <= next_pend;
			pend_q <= next_pend_q;
			left <= next_left;
			sub <= next_sub;
			xoff_state <= next_xoff_state;
			host_pause_request_out <= next_host_req;
			ig_in_frame <= next_ig_in_frame;
			ig_drop <= next_ig_drop;
			// a new event wins over a clear in the same cycle
			sticky_out <= (sticky_out & ~sticky_clear_in) | ev;
		end
	end
endmodule
`default_nettype wire

// ==== efcb_host_sink.sv ====
/*
 far-side sink model: host or line mac taking words off a valid/ready output.
 assumes clk_in from the bench; stall_in holds ready low, fast_in gives ready every cycle.
*/
`default_nettype none
module efcb_host_sink (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic stall_in,
	input wire logic fast_in,
	output logic ready_out
);
	logic phase;
	// slow mode takes one word in two, so the buffer must hold words back
	always_ff @(posedge clk_in)
		phase <= rstn_in ? !phase : 1'b0;
	assign ready_out = !stall_in && (fast_in || phase);
endmodule
`default_nettype wire

// ==== efcb_buffer_props.sv ====
/*
 concurrent checks on the flow control buffer ports.
 assumes the bind below and the parameters of the buffer.
*/
`default_nettype none
module efcb_buffer_chk
	import efcb_pkg::*;
#(
	parameter int DATA_W = 64,
	parameter int MTU_BYTES = 10240,
	localparam int ADDR_W = $clog2(EFCB_MTU_MULT * (MTU_BYTES / (DATA_W / 8)))
)(
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic pause_reaction_enable_in,
	input wire logic host_pause_signal_enable_in,
	input wire logic merge_line_pause_into_request_in,
	input wire logic line_pause_valid_in,
	input wire logic [EFCB_QUANTA_W-1:0] line_pause_quanta_in,
	input wire logic [ADDR_W:0] xon_threshold_in,
	input wire logic [ADDR_W:0] data_fill_out,
	input wire logic egress_paused_out,
	input wire logic host_pause_request_out,
	input wire logic [EFCB_CNT_W-1:0] ingress_overflow_drops_out,
	input wire logic [EFCB_NUM_STICKY-1:0] sticky_out,
	input wire logic [EFCB_NUM_STICKY-1:0] sticky_clear_in,
	input wire logic ig_valid_in,
	input wire logic ig_out_valid_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rstn_in);
	sequence s_zero_pause;
		line_pause_valid_in && pause_reaction_enable_in && line_pause_quanta_in == 16'h0000;
	endsequence
	sequence s_below_xon;
		!merge_line_pause_into_request_in && data_fill_out <= xon_threshold_in;
	endsequence
	AST_ZERO_END: assert property (s_zero_pause ##1 pause_reaction_enable_in |=> !egress_paused_out)
		else $error("pause kept after zero quanta");
	AST_REACT_OFF: assert property (!pause_reaction_enable_in [*2] |-> !egress_paused_out)
		else $error("paused with reaction off");
	AST_MERGE_REQ: assert property (merge_line_pause_into_request_in && egress_paused_out |=> host_pause_request_out)
		else $error("no request while paused");
	AST_THR_ONLY: assert property (!host_pause_signal_enable_in && !merge_line_pause_into_request_in |=> !host_pause_request_out)
		else $error("request with both sources off");
	AST_XON: assert property (s_below_xon [*2] |=> !host_pause_request_out)
		else $error("request kept below xon");
	AST_CNT_STEP: assert property ($changed(ingress_overflow_drops_out) |-> ingress_overflow_drops_out == $past(ingress_overflow_drops_out) + 32'h1)
		else $error("drop counter jumped");
	AST_STICKY_KEEP: assert property (sticky_out[3] && !sticky_clear_in[3] |=> sticky_out[3])
		else $error("sticky bit lost");
	AST_ING_VALID: assert property (ig_valid_in |=> ig_out_valid_out)
		else $error("ingress word not offered");
endmodule
bind efcb_buffer efcb_buffer_chk #(.DATA_W(DATA_W), .MTU_BYTES(MTU_BYTES)) i_efcb_buffer_chk (.*);
`default_nettype wire

// ==== efcb_buffer_tb.sv ====
/*
 self-checking bench for the flow control buffer, shortened depth and quantum.
 assumes efcb_pkg, the sink model and the bound checker are compiled before it.
*/
`default_nettype none
module efcb_buffer_tb;
	import efcb_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct {int n; logic [63:0] b; logic sp;} efcb_row_s;
	efcb_row_s rows [4] = '{'{1, 64'h10, 1'b0}, '{3, 64'h20, 1'b0}, '{1, 64'h5a, 1'b1}, '{6, 64'h30, 1'b0}};
	logic clk_in = 0, rstn_in = 0, pre = 1, hpe = 0, mrg = 0, inj = 0, pv = 0, stall = 0, fast = 0;
	logic istall = 0, eg_valid = 0, eg_last = 0, eg_sp = 0, ig_valid = 0, ig_last = 0;
	logic cqe = 0, dinj = 0, mctl = 0;
	logic eg_ready, eo_valid, eo_ready, eo_sp, io_valid, io_ready, req, paused;
	logic [15:0] pq = 16'h0000;
	logic [63:0] eg_data = 64'h0, ig_data = 64'h0, eo_data, io_data;
	logic [7:0] xoff = 8'h0a, xon = 8'h04, fill;
	logic [6:0] dend = 7'h7e;
	logic [31:0] ig_drops;
	logic [4:0] sticky, sclr = 5'h00;
	logic [64:0] exp_q [$];
	int err_count = 0, compares = 0, cycles = 0;
	efcb_buffer #(.MTU_BYTES(256), .QUANTUM_CYCLES(2)) i_efcb_buffer (.clk_in(clk_in),
		.rstn_in(rstn_in), .pause_reaction_enable_in(pre), .host_pause_signal_enable_in(hpe),
		.merge_line_pause_into_request_in(mrg), .egress_control_queue_enable_in(cqe),
		.xoff_threshold_in(xoff), .xon_threshold_in(xon), .ctrl_queue_start_in(7'h7f),
		.ctrl_queue_end_in(7'h7f), .data_queue_start_in(7'h00), .data_queue_end_in(dend),
		.ecc_inject_single_in(inj), .ecc_inject_double_in(dinj), .line_pause_valid_in(pv),
		.line_pause_quanta_in(pq), .eg_valid_in(eg_valid), .eg_ready_out(eg_ready),
		.eg_data_in(eg_data), .eg_last_in(eg_last), .eg_special_in(eg_sp), .eg_mac_ctrl_in(mctl),
		.eg_out_valid_out(eo_valid), .eg_out_ready_in(eo_ready), .eg_out_data_out(eo_data),
		.eg_out_last_out(), .eg_out_special_out(eo_sp), .eg_out_abort_out(), .ig_valid_in(ig_valid),
		.ig_data_in(ig_data), .ig_last_in(ig_last), .ig_special_in(eg_sp),
		.ig_out_valid_out(io_valid), .ig_out_ready_in(io_ready), .ig_out_data_out(io_data),
		.ig_out_last_out(), .ig_out_special_out(), .ig_out_abort_out(),
		.host_pause_request_out(req), .egress_paused_out(paused), .data_fill_out(fill),
		.ctrl_overflow_drops_out(), .ctrl_ecc_drops_out(), .data_ecc_drops_out(),
		.ingress_overflow_drops_out(ig_drops), .sticky_out(sticky), .sticky_clear_in(sclr));
	efcb_host_sink i_efcb_host_sink (.clk_in(clk_in), .rstn_in(rstn_in), .stall_in(stall),
		.fast_in(fast), .ready_out(eo_ready));
	efcb_host_sink i_efcb_host_sink_ig (.clk_in(clk_in), .rstn_in(rstn_in), .stall_in(istall),
		.fast_in(1'b1), .ready_out(io_ready));
	always #5 clk_in = !clk_in;
	task automatic chk(input logic [64:0] got, input logic [64:0] exp);
		compares++;
		if (got !== exp)
		begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic test_done;
		$display("compares %0d err_count %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask
	// host side never splits a frame: stops only at a boundary
	task automatic send(input int n, input logic [63:0] b, input logic s);
		for (int i = 0; i < n; i++)
		begin
			eg_valid = 1;
			eg_data = b + i;
			eg_last = (i == n - 1);
			eg_sp = s;
			do @(negedge clk_in); while (eg_ready !== 1'b1);
			exp_q.push_back({s, b + 64'(i)});
			tick(1);
		end
		eg_valid = 0;
	endtask
	////////////////////////////////////////////////////////////////////////////////////////
	always @(negedge clk_in)
		if (eo_valid === 1'b1 && eo_ready === 1'b1)
			chk({eo_sp, eo_data}, exp_q.size() > 0 ? exp_q.pop_front() : 65'h0);
	always @(posedge clk_in)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			err_count++;
			test_done();
		end
	end
	initial
	begin
		tick(3);
		rstn_in = 1;
		chk({paused, req, eg_ready, sticky, ig_drops}, 65'h2000000000);
		foreach (rows[k])
		begin
			inj = (k == 3);
			send(rows[k].n, rows[k].b, rows[k].sp);
		end
		fast = 1;
		tick(40);
		mrg = 1;
		pv = 1;
		pq = 16'h0003;
		tick(1);
		pv = 0;
		tick(1);
		chk(paused, 65'h1);
		send(2, 64'h40, 0);
		chk({paused, req, eo_valid, sticky[4]}, 65'hd);
		pv = 1;
		pq = 16'h0000;
		tick(1);
		pv = 0;
		tick(2);
		chk(paused, 65'h0);
		mrg = 0;
		hpe = 1;
		stall = 1;
		send(12, 64'h100, 0);
		tick(3);
		chk(req, 65'h1);
		stall = 0;
		tick(40);
		chk({req, 65'(exp_q.size())}, 65'h0);
		istall = 1;
		for (int i = 0; i < 4; i++)
		begin
			ig_valid = 1;
			ig_data = 64'h200 + 64'(i);
			ig_last = (i == 3);
			tick(1);
		end
		ig_valid = 0;
		tick(1);
		chk({io_data, sticky[3]}, {64'h200, 1'b1});
		chk(ig_drops, 65'h1);
		sclr = 5'h08;
		tick(1);
		sclr = 5'h00;
		pre = 0;
		istall = 0;
		tick(2);
		chk({sticky[3], paused}, 65'h0);
		test_done();
	end
endmodule
`default_nettype wire
